//--- rtl/wsv_top.sv
// watchdog, brownout and supply detection supervisor
// ************************************************************
// ************************************************************
`timescale 1ns/1ps
module wsv_top
   import wsv_pkg::*;
#(
   parameter bit WD_AT_POR   = 1'b0,
   parameter int POR_CYC     = (WSV_POR_US * (WSV_RC_HZ / 1_000_000)),
   parameter int TO0_CYC     = (WSV_TO0_MS * (WSV_RC_HZ / 1000)),
   parameter int TO1_CYC     = (WSV_TO1_MS * (WSV_RC_HZ / 1000)),
   parameter int TO2_CYC     = (WSV_TO2_MS * (WSV_RC_HZ / 1000)),
   parameter int TO3_CYC     = (WSV_TO3_MS * (WSV_RC_HZ / 1000))
) (
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_resetn,
   // register access from the core
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   // core events
   input  wire logic       i_refresh,
   input  wire logic       i_first_instr,
   input  wire logic       i_halt,
   input  wire logic       i_stop,
   input  wire logic       i_stop_recover,
   input  wire logic       i_supply_interrupt_request_clear,
   input  wire logic       i_supply_interrupt_request_mask,
   // analog comparators
   input  wire logic       i_brownout,
   input  wire logic       i_vdd_high,
   input  wire logic       i_vdd_low,
   // outputs to the core
   output logic            o_zero_flag,
   output logic            o_sign_flag,
   output logic            o_ovf_flag,
   output logic            o_flag_update,
   output logic            o_sys_reset,
   output logic            o_supply_irq_req,
   output logic            o_supply_irq_serve
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic bo_s;
   logic hi_s;
   logic lo_s;
   wsv_sync u_sync_bo (
      .i_mclk  (i_mclk),
      .i_resetn(i_resetn),
      .i_d     (i_brownout),
      .o_q     (bo_s)
   );
   wsv_sync u_sync_hi (
      .i_mclk  (i_mclk),
      .i_resetn(i_resetn),
      .i_d     (i_vdd_high),
      .o_q     (hi_s)
   );
   wsv_sync u_sync_lo (
      .i_mclk  (i_mclk),
      .i_resetn(i_resetn),
      .i_d     (i_vdd_low),
      .o_q     (lo_s)
   );

   // ************************************************************
   // reset sequencer
   // ************************************************************
   typedef enum logic [1:0] {WSV_RUN, WSV_BROWN, WSV_POR} wsv_state_t;
   wsv_state_t st_q;
   logic       wd_done;
   logic       por_done;
   logic       por_start;
   logic       in_por;
   assign in_por    = (st_q != WSV_RUN);
   assign por_start = (st_q == WSV_BROWN) && !bo_s;

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         st_q <= WSV_POR;
      end else begin
         case (st_q)
            WSV_RUN: begin
               if (bo_s) begin
                  st_q <= WSV_BROWN;
               end else if (wd_done) begin
                  st_q <= WSV_POR;
               end
            end
            WSV_BROWN: begin
               if (por_start) begin
                  st_q <= WSV_POR;
               end
            end
            WSV_POR: begin
               if (bo_s) begin
                  st_q <= WSV_BROWN;
               end else if (por_done) begin
                  st_q <= WSV_RUN;
               end
            end
            default: st_q <= WSV_POR;
         endcase
      end
   end

   // one-shot power-on timer restarted by every reset source
   wsv_timer #(.W(32)) u_por (
      .i_mclk  (i_mclk),
      .i_resetn(i_resetn),
      .i_clear (st_q != WSV_POR),
      .i_run   (1'b1),
      .i_limit (32'(POR_CYC)),
      .o_done  (por_done)
   );

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_sys_reset <= 1'b1;
      end else begin
         o_sys_reset <= (st_q != WSV_RUN) || bo_s || wd_done;
      end
   end

   // ************************************************************
   // watchdog mode register and write window
   // ************************************************************
   logic [3:0] wdmode_q;
   logic [7:0] win_q;
   logic       win_open_q;
   logic       win_arm_q;
   logic       wm_wr_ok;
   assign wm_wr_ok = i_wr && (i_addr == WSV_WDMODE_OFFS)
                     && (win_open_q || (win_arm_q && i_first_instr));

   always_ff @(posedge i_mclk) begin
      if (!i_resetn || in_por || i_stop_recover) begin
         win_arm_q  <= 1'b1;
         win_open_q <= 1'b0;
         win_q      <= 8'h00;
      end else if (win_arm_q && i_first_instr) begin
         win_arm_q  <= 1'b0;
         win_open_q <= 1'b1;
      end else if (win_open_q) begin
         if (win_q == 8'(WSV_WR_WIN_CYC - 1)) begin
            win_open_q <= 1'b0;
         end
         win_q <= win_q + 8'h01;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn || (in_por && !(st_q == WSV_POR && wd_done))) begin
         wdmode_q <= WSV_WDMODE_RST;
      end else if (wm_wr_ok) begin
         wdmode_q <= i_wdata[3:0];
      end
   end

   // ************************************************************
   // watchdog counter on the rc time base
   // ************************************************************
   logic        wd_en_q;
   logic [31:0] wd_limit;
   logic        wd_run;
   always_comb begin
      case (wdmode_q[1:0])
         2'b00:   wd_limit = 32'(TO0_CYC);
         2'b01:   wd_limit = 32'(TO1_CYC);
         2'b10:   wd_limit = 32'(TO2_CYC);
         default: wd_limit = 32'(TO3_CYC);
      endcase
   end
   assign wd_run = wd_en_q && !in_por
                   && !(i_halt && !wdmode_q[WSV_WM_HALT_BIT])
                   && !(i_stop && !wdmode_q[WSV_WM_STOP_BIT]);

   always_ff @(posedge i_mclk) begin
      if (!i_resetn || (st_q == WSV_BROWN)) begin
         wd_en_q <= WD_AT_POR;
      end else if (i_refresh && !in_por) begin
         wd_en_q <= 1'b1;
      end
   end

   // counts the rc-derived tick base
   wsv_timer #(.W(32)) u_wd (
      .i_mclk  (i_mclk),
      .i_resetn(i_resetn),
      .i_clear (i_refresh || in_por),
      .i_run   (wd_run),
      .i_limit (wd_limit),
      .o_done  (wd_done)
   );

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_flag_update <= 1'b0;
         o_zero_flag   <= 1'b0;
         o_sign_flag   <= 1'b0;
         o_ovf_flag    <= 1'b0;
      end else begin
         o_flag_update <= i_refresh;
         if (i_refresh) begin
            o_zero_flag <= 1'b0;
            o_sign_flag <= 1'b0;
            o_ovf_flag  <= 1'b0;
         end
      end
   end

   // ************************************************************
   // supply detection
   // ************************************************************
   logic        vd_en_q;
   logic        vd_valid;
   logic        hi_flag_q;
   logic        lo_flag_q;
   logic        supply_interrupt_request_q;
   logic        vd_live;
   assign vd_live = vd_en_q && !i_stop;

   always_ff @(posedge i_mclk) begin
      if (!i_resetn || in_por) begin
         vd_en_q <= 1'b0;
      end else if (i_wr && i_addr == WSV_SUPPLY_OFFS) begin
         vd_en_q <= i_wdata[WSV_SD_EN_BIT];
      end
   end

   wsv_timer #(.W(16)) u_vd (
      .i_mclk  (i_mclk),
      .i_resetn(i_resetn),
      .i_clear (!vd_live),
      .i_run   (1'b1),
      .i_limit (16'(WSV_VD_SETTLE_CYC)),
      .o_done  (vd_valid)
   );

   always_ff @(posedge i_mclk) begin
      if (!i_resetn || in_por) begin
         hi_flag_q <= 1'b0;
         lo_flag_q <= 1'b0;
      end else begin
         hi_flag_q <= vd_live && vd_valid && hi_s;
         lo_flag_q <= vd_live && vd_valid && lo_s;
      end
   end

   // set wins over clear; noise from port mode writes is left to software
   always_ff @(posedge i_mclk) begin
      if (!i_resetn || in_por) begin
         supply_interrupt_request_q <= 1'b0;
      end else if (vd_live && lo_flag_q) begin
         supply_interrupt_request_q <= 1'b1;
      end else if (i_supply_interrupt_request_clear) begin
         supply_interrupt_request_q <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_supply_irq_req   <= 1'b0;
         o_supply_irq_serve <= 1'b0;
      end else begin
         o_supply_irq_req   <= supply_interrupt_request_q;
         o_supply_irq_serve <= supply_interrupt_request_q && i_supply_interrupt_request_mask;
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_rdata <= WSV_RD_ZERO;
      end else if (i_rd && i_addr == WSV_SUPPLY_OFFS) begin
         o_rdata <= {5'h00, hi_flag_q, lo_flag_q, vd_en_q};
      end else begin
         o_rdata <= WSV_RD_ZERO;
      end
   end
endmodule

//--- rtl/wsv_pkg.sv
// package of constants for the watchdog and supply supervisor
package wsv_pkg;
   // ************************************************************
   // register map (expanded register file)
   // ************************************************************
   localparam logic [7:0] WSV_SUPPLY_OFFS   = 8'h0c;
   localparam logic [7:0] WSV_WDMODE_OFFS   = 8'h0f;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int         WSV_SD_EN_BIT     = 0;
   localparam int         WSV_SD_LOW_BIT    = 1;
   localparam int         WSV_SD_HIGH_BIT   = 2;
   localparam int         WSV_WM_HALT_BIT   = 2;
   localparam int         WSV_WM_STOP_BIT   = 3;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [3:0] WSV_WDMODE_RST    = 4'hc;
   localparam logic [7:0] WSV_RD_ZERO       = 8'h00;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int         WSV_CLK_HZ        = 50_000_000;
   localparam int         WSV_WR_WIN_CYC    = 120;
   localparam int         WSV_VD_SETTLE_US  = 20;
   localparam int         WSV_VD_SETTLE_CYC = (WSV_VD_SETTLE_US * (WSV_CLK_HZ / 1_000_000));
   localparam int         WSV_TO0_MS        = 10;
   localparam int         WSV_TO1_MS        = 20;
   localparam int         WSV_TO2_MS        = 40;
   localparam int         WSV_TO3_MS        = 160;
   localparam int         WSV_POR_US        = 2500;
   localparam int         WSV_RC_HZ         = 50_000_000;
endpackage

//--- rtl/wsv_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module wsv_sync (
   // clock and reset
   input  wire logic i_mclk,
   input  wire logic i_resetn,
   // level
   input  wire logic i_d,
   output logic      o_q
);
   logic meta_q;
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         meta_q <= 1'b0;
         o_q    <= 1'b0;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule

//--- rtl/wsv_timer.sv
// cycle counter with clear, hold and terminal flag held until clear
`timescale 1ns/1ps
module wsv_timer #(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_resetn,
   // control
   input  wire logic         i_clear,
   input  wire logic         i_run,
   input  wire logic [W-1:0] i_limit,
   // status
   output logic              o_done
);
   logic [W-1:0] cnt_q;
   always_ff @(posedge i_mclk) begin
      if (!i_resetn || i_clear) begin
         cnt_q  <= '0;
         o_done <= 1'b0;
      end else if (i_run && !o_done) begin
         if (cnt_q + W'(1) >= i_limit) begin
            o_done <= 1'b1;
         end
         cnt_q <= cnt_q + W'(1);
      end
   end
endmodule

//--- testbench/wsv_props.sv
// checker of the supervisor port behaviour
`timescale 1ns/1ps
module wsv_props
   import wsv_pkg::*;
#(
   parameter int POR_CYC = 50,
   parameter int TO0_CYC = 100
) (
   input wire logic       i_mclk,
   input wire logic       i_resetn,
   input wire logic       i_rd,
   input wire logic [7:0] i_addr,
   input wire logic       i_refresh,
   input wire logic       i_supply_interrupt_request_clear,
   input wire logic       i_supply_interrupt_request_mask,
   input wire logic       i_brownout,
   input wire logic [7:0] o_rdata,
   input wire logic       o_zero_flag,
   input wire logic       o_sign_flag,
   input wire logic       o_ovf_flag,
   input wire logic       o_flag_update,
   input wire logic       o_sys_reset,
   input wire logic       o_supply_irq_req,
   input wire logic       o_supply_irq_serve
);
   int hi_q;
   int idle_q;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   always_ff @(posedge i_mclk) begin
      hi_q <= (!i_resetn || !o_sys_reset) ? 0 : hi_q + 1;
   end
   always_ff @(posedge i_mclk) begin
      idle_q <= (!i_resetn || i_refresh) ? 0 : idle_q + ((idle_q < TO0_CYC) ? 1 : 0);
   end
   property p_wm_read; i_rd && i_addr == WSV_WDMODE_OFFS |=> o_rdata == 8'h00; endproperty
   a_wm_read: assert property (p_wm_read) else $error("mode read not zero");
   property p_flag_clr; i_refresh && !o_sys_reset |=> o_flag_update &&
      !(o_zero_flag || o_sign_flag || o_ovf_flag); endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flags not updated");
   property p_flag_cause; o_flag_update |-> $past(i_refresh); endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("stray flag update");
   property p_irq_hold; o_supply_irq_req && !i_supply_interrupt_request_clear && !$past(i_supply_interrupt_request_clear)
      && !o_sys_reset && !i_brownout |=> o_supply_irq_req || o_sys_reset; endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("request lost");
   property p_irq_serve; o_supply_irq_req && i_supply_interrupt_request_mask && !i_supply_interrupt_request_clear
      && !$past(i_supply_interrupt_request_clear) && !o_sys_reset |=> o_supply_irq_serve; endproperty
   a_irq_serve: assert property (p_irq_serve) else $error("request not served");
   property p_brownout; i_brownout [*4] |=> o_sys_reset; endproperty
   a_brownout: assert property (p_brownout) else $error("no brownout reset");
   property p_por_len; $fell(o_sys_reset) |-> hi_q >= POR_CYC - 2; endproperty
   a_por_len: assert property (p_por_len) else $error("reset too short");
   property p_wd_min; $rose(o_sys_reset) && !i_brownout |-> idle_q >= TO0_CYC - 2; endproperty
   a_wd_min: assert property (p_wd_min) else $error("watchdog fired early");
endmodule

bind wsv_top wsv_props #(.POR_CYC(POR_CYC), .TO0_CYC(TO0_CYC)) wsv_props_i (.*);

//--- testbench/wsv_top_bench.sv
// self-checking bench of the supervisor
`timescale 1ns/1ps
module wsv_top_bench;
   import wsv_pkg::*;
   localparam int POR_C = 50;
   logic       i_mclk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_refresh = 0;
   logic       i_first_instr = 0, i_halt = 0, i_stop = 0, i_stop_recover = 0;
   logic       i_supply_interrupt_request_clear = 0, i_supply_interrupt_request_mask = 0, i_brownout = 0, i_vdd_high = 0;
   logic       i_vdd_low = 0, o_zero_flag, o_sign_flag, o_ovf_flag, o_flag_update;
   logic       o_sys_reset, o_supply_irq_req, o_supply_irq_serve;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
   int         fail_count = 0, checked = 0, cyc = 0;
   wsv_top #(.POR_CYC(POR_C), .TO0_CYC(100), .TO1_CYC(200), .TO2_CYC(400),
      .TO3_CYC(1600)) wsv_top_i (.*);
   always #10 i_mclk = ~i_mclk;
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic tick(int n = 1);
      repeat (n) @(negedge i_mclk);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      i_wr = 1;
      i_addr = a;
      i_wdata = d;
      tick();
      i_wr = 0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp, string name);
      i_rd = 1;
      i_addr = a;
      tick();
      i_rd = 0;
      chk(name, exp, o_rdata);
      tick();
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      tick();
      s = 0;
      tick();
   endtask
   // counts cycles until the reset output reaches lvl and checks the span
   task automatic wait_rst(logic lvl, int lo, int hi, string name);
      int n;
      n = 0;
      while (o_sys_reset !== lvl && n <= hi) begin
         n++;
         tick();
      end
      chk(name, 8'h01, {7'h00, n >= lo && n <= hi});
   endtask
   task automatic t_supply();
      i_vdd_high = 1;
      wr(WSV_SUPPLY_OFFS, 8'h01);
      tick(WSV_VD_SETTLE_CYC + 10);
      rd(WSV_SUPPLY_OFFS, 8'h05, "high flag");
      i_vdd_high = 0;
      i_vdd_low = 1;
      tick(5);
      rd(WSV_SUPPLY_OFFS, 8'h03, "low flag");
      chk("irq req", 8'h01, {7'h00, o_supply_irq_req});
      chk("unmasked", 8'h00, {7'h00, o_supply_irq_serve});
      i_supply_interrupt_request_mask = 1;
      i_vdd_low = 0;
      tick(5);
      chk("served", 8'h01, {7'h00, o_supply_irq_serve});
      chk("latched", 8'h01, {7'h00, o_supply_irq_req});
      pulse(i_supply_interrupt_request_clear);
      chk("cleared", 8'h00, {7'h00, o_supply_irq_req});
      i_supply_interrupt_request_mask = 0;
      i_stop = 1;
      i_vdd_low = 1;
      tick(5);
      chk("stop", 8'h00, {7'h00, o_supply_irq_req});
      i_stop = 0;
      chk("no wd at por", 8'h00, {7'h00, o_sys_reset});
   endtask
   task automatic t_brown();
      i_vdd_low = 0;
      i_brownout = 1;
      tick(6);
      chk("brownout", 8'h01, {7'h00, o_sys_reset});
      i_brownout = 0;
      wait_rst(1'b0, POR_C - 2, 400, "brown por");
      rd(WSV_SUPPLY_OFFS, 8'h00, "supply por");
   endtask
   task automatic t_window();
      pulse(i_first_instr);
      wr(WSV_WDMODE_OFFS, 8'hf1);
      tick(WSV_WR_WIN_CYC + 10);
      wr(WSV_WDMODE_OFFS, 8'h03);
      repeat (3) begin
         pulse(i_refresh);
         tick(150);
         chk("refreshed", 8'h00, {7'h00, o_sys_reset});
      end
      pulse(i_refresh);
      wait_rst(1'b1, 195, 210, "timeout");
      wait_rst(1'b0, POR_C - 2, 400, "wd por");
   endtask
   task automatic t_halt();
      pulse(i_first_instr);
      wr(WSV_WDMODE_OFFS, 8'h00);
      pulse(i_refresh);
      i_halt = 1;
      tick(300);
      chk("halt", 8'h00, {7'h00, o_sys_reset});
      i_halt = 0;
      i_stop = 1;
      tick(300);
      chk("stop wd", 8'h00, {7'h00, o_sys_reset});
      i_stop = 0;
      wait_rst(1'b1, 85, 110, "paused");
   endtask
   task automatic t_recover();
      wait_rst(1'b0, POR_C - 2, 400, "halt por");
      pulse(i_refresh);
      pulse(i_first_instr);
      tick(60);
      pulse(i_refresh);
      tick(70);
      pulse(i_stop_recover);
      pulse(i_first_instr);
      wr(WSV_WDMODE_OFFS, 8'h03);
      pulse(i_refresh);
      tick(120);
      chk("recover window", 8'h00, {7'h00, o_sys_reset});
   endtask
   initial begin
      tick(2);
      i_resetn = 1;
      wait_rst(1'b0, POR_C - 2, 400, "boot por");
      rd(WSV_WDMODE_OFFS, 8'h00, "mode read");
      rd(WSV_SUPPLY_OFFS, 8'h00, "supply rst");
      t_supply();
      t_brown();
      t_window();
      t_halt();
      t_recover();
      finish_test();
   end
endmodule
